// ### include/pktbuf_pkg.sv
// package: register map, field layout and sizes of the packet buffer debug port
package pktbuf_pkg;
  // register byte addresses on the 32-bit wishbone bus
  // the data word has printed index 2; the command word has no printed offset
  localparam logic [3:0] DATA_IDX = 4'h2;
  localparam logic [5:0] ADDR_DATA_LO = {DATA_IDX, 2'b00};
  localparam logic [5:0] ADDR_DATA_HI = {DATA_IDX + 4'h1, 2'b00};
  localparam logic [5:0] ADDR_CMD = 6'h10;
  localparam logic [5:0] ADDR_STAT = 6'h14;
  localparam logic [5:0] ADDR_ENG = 6'h18;
  // command register fields
  localparam int CMD_READ_BIT = 15;
  localparam int CMD_GO_BIT = 14;
  localparam int CMD_TX_BIT = 13;
  localparam int CMD_ADDR_HI = 9;
  localparam logic [15:0] CMD_RESET = 16'h0000;
  // go is readable so software can poll it while the request is pending
  localparam logic [15:0] CMD_RW_MASK = 16'hE3FF;
  // buffer geometry
  localparam int PAGE_BYTES = 256;
  localparam int RX_PAGES = 32;
  localparam int TX_PAGES = 16;
  localparam int WORD_BYTES = 8;
  localparam int RX_WORDS = RX_PAGES * PAGE_BYTES / WORD_BYTES;
  localparam int TX_WORDS = TX_PAGES * PAGE_BYTES / WORD_BYTES;
  localparam int RX_AW = $clog2(RX_WORDS);
  localparam int TX_AW = $clog2(TX_WORDS);
  localparam int HDR_BYTES = 8;

  typedef struct packed {
    logic [15:0] nextPage;
    logic [15:0] secondPage;
    logic [15:0] frameLen;
    logic [15:0] frameLenInv;
  } status_hdr_t;

  typedef struct packed {
    logic read;
    logic go;
    logic txSel;
    logic [2:0] rsvd;
    logic [9:0] wordAddr;
  } cmd_t;

  typedef struct packed {
    logic req;
    logic we;
    logic [RX_AW-1:0] addr;
    logic [63:0] wdata;
  } mem_req_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_WAIT = 4'b0010,
    ST_ACCESS = 4'b0100,
    ST_DONE = 4'b1000
  } arb_state_t;

  function automatic status_hdr_t make_header(input logic [15:0] nxt, input logic [15:0] sec,
                                             input logic [15:0] len);
    status_hdr_t h;
    h.nextPage = nxt;
    h.secondPage = sec;
    h.frameLen = len;
    h.frameLenInv = ~len;
    return h;
  endfunction : make_header
endpackage : pktbuf_pkg

// ### rtl/packet_buffer_debug_access.sv
// packet buffer memories with arbiter and wishbone debug access port
`timescale 1ns/1ps
`default_nettype none
module packet_buffer_debug_access #(
  parameter int RX_WORDS = pktbuf_pkg::RX_WORDS,
  parameter int TX_WORDS = pktbuf_pkg::TX_WORDS
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // engine (mac / offload engine) port, same clock
  input wire logic engReq,
  input wire logic engTx,
  input wire logic engWe,
  input wire logic [9:0] engAddr,
  input wire logic [63:0] engWdata,
  output logic engGrant,
  output logic engValid,
  output logic [63:0] engRdata,
  // header built for the engine
  input wire logic [15:0] hdrNextPage,
  input wire logic [15:0] hdrSecondPage,
  input wire logic [15:0] hdrLength,
  output logic [63:0] hdrWord
);
  localparam int RX_AW = $clog2(RX_WORDS);
  localparam int TX_AW = $clog2(TX_WORDS);

  pktbuf_pkg::cmd_t cmd_q;
  logic [63:0] dataWord_q;
  pktbuf_pkg::arb_state_t state_q;
  logic engBusy_q;
  logic engTxSel_q;
  logic dbgTxSel_q;
  logic [15:0] collisions_q;

  logic wbReq;
  logic wbWrite;
  logic rxEn;
  logic rxWe;
  logic txEn;
  logic txWe;
  logic [RX_AW-1:0] rxAddr;
  logic [TX_AW-1:0] txAddr;
  logic [63:0] memWdata;
  logic [63:0] rxRdata;
  logic [63:0] txRdata;
  logic engWins;
  logic dbgGo;

  function automatic logic [31:0] merge_lanes(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge_lanes

  // rx and tx are two independent memories
  pkt_sram #(.WORDS(RX_WORDS), .AW(RX_AW)) rxMem (
    .clock(clock),
    .en(rxEn),
    .we(rxWe),
    .addr(rxAddr),
    .wdata(memWdata),
    .rdata(rxRdata)
  );

  pkt_sram #(.WORDS(TX_WORDS), .AW(TX_AW)) txMem (
    .clock(clock),
    .en(txEn),
    .we(txWe),
    .addr(txAddr),
    .wdata(memWdata),
    .rdata(txRdata)
  );

  assign wbReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // a write lands on the edge at which the master samples ack high, not earlier
  assign wbWrite = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;

  // engine wins the port unless it was granted the cycle before; debug waits so no packet access is disturbed
  assign engWins = engReq && !engBusy_q;
  assign dbgGo = (state_q == pktbuf_pkg::ST_WAIT) && !engReq;

  // memory port mux
  always_comb begin
    rxEn = 1'b0;
    rxWe = 1'b0;
    txEn = 1'b0;
    txWe = 1'b0;
    rxAddr = '0;
    txAddr = '0;
    memWdata = dataWord_q;
    if (engWins) begin
      memWdata = engWdata;
      rxAddr = engAddr[RX_AW-1:0];
      txAddr = engAddr[TX_AW-1:0];
      rxEn = !engTx;
      txEn = engTx;
      rxWe = !engTx && engWe;
      txWe = engTx && engWe;
    end else if (dbgGo) begin
      rxAddr = cmd_q.wordAddr[RX_AW-1:0];
      txAddr = cmd_q.wordAddr[TX_AW-1:0];
      rxEn = !cmd_q.txSel;
      txEn = cmd_q.txSel;
      rxWe = !cmd_q.txSel && !cmd_q.read;
      txWe = cmd_q.txSel && !cmd_q.read;
    end
  end

  // debug request sequencer
  always_ff @(posedge clock) begin
    if (reset) begin
      state_q <= pktbuf_pkg::ST_IDLE;
    end else begin
      unique case (state_q)
        pktbuf_pkg::ST_IDLE: begin
          if (cmd_q.go) begin
            state_q <= pktbuf_pkg::ST_WAIT;
          end
        end
        pktbuf_pkg::ST_WAIT: begin
          if (dbgGo) begin
            state_q <= pktbuf_pkg::ST_ACCESS;
          end
        end
        pktbuf_pkg::ST_ACCESS: begin
          state_q <= pktbuf_pkg::ST_DONE;
        end
        pktbuf_pkg::ST_DONE: begin
          state_q <= pktbuf_pkg::ST_IDLE;
        end
        default: begin
          state_q <= pktbuf_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      dbgTxSel_q <= 1'b0;
    end else if (dbgGo) begin
      dbgTxSel_q <= cmd_q.txSel;
    end
  end

  // command register
  always_ff @(posedge clock) begin
    if (reset) begin
      cmd_q <= pktbuf_pkg::CMD_RESET;
    end else begin
      if (wbWrite && wb_adr_i == pktbuf_pkg::ADDR_CMD && !cmd_q.go) begin
        if (wb_sel_i[0]) begin
          cmd_q.wordAddr[7:0] <= wb_dat_i[7:0];
        end
        if (wb_sel_i[1]) begin
          cmd_q.wordAddr[9:8] <= wb_dat_i[9:8];
          cmd_q.txSel <= wb_dat_i[pktbuf_pkg::CMD_TX_BIT];
          cmd_q.read <= wb_dat_i[pktbuf_pkg::CMD_READ_BIT];
          if (wb_dat_i[pktbuf_pkg::CMD_GO_BIT]) begin
            cmd_q.go <= 1'b1;
          end
        end
      end
      if (state_q == pktbuf_pkg::ST_DONE) begin
        cmd_q.go <= 1'b0;
      end
    end
  end

  // data word: software lanes, and read data captured on completion
  always_ff @(posedge clock) begin
    if (reset) begin
      dataWord_q <= '0;
    end else if (state_q == pktbuf_pkg::ST_ACCESS && cmd_q.read) begin
      dataWord_q <= dbgTxSel_q ? txRdata : rxRdata;
    end else if (wbWrite && !cmd_q.go && wb_adr_i == pktbuf_pkg::ADDR_DATA_LO) begin
      dataWord_q[31:0] <= merge_lanes(dataWord_q[31:0], wb_dat_i, wb_sel_i);
    end else if (wbWrite && !cmd_q.go && wb_adr_i == pktbuf_pkg::ADDR_DATA_HI) begin
      dataWord_q[63:32] <= merge_lanes(dataWord_q[63:32], wb_dat_i, wb_sel_i);
    end
  end

  // count of debug cycles held off by engine traffic, for visibility
  always_ff @(posedge clock) begin
    if (reset) begin
      collisions_q <= '0;
    end else if (state_q == pktbuf_pkg::ST_WAIT && engReq) begin
      collisions_q <= collisions_q + 16'h0001;
    end
  end

  // engine port answers
  always_ff @(posedge clock) begin
    if (reset) begin
      engBusy_q <= 1'b0;
      engTxSel_q <= 1'b0;
      engGrant <= 1'b0;
      engValid <= 1'b0;
    end else begin
      engBusy_q <= engWins;
      engTxSel_q <= engTx;
      engGrant <= engWins;
      engValid <= engBusy_q;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      engRdata <= '0;
    end else if (engBusy_q) begin
      engRdata <= engTxSel_q ? txRdata : rxRdata;
    end
  end

  // status header for frames being stored
  always_ff @(posedge clock) begin
    if (reset) begin
      hdrWord <= '0;
    end else begin
      hdrWord <= pktbuf_pkg::make_header(hdrNextPage, hdrSecondPage, hdrLength);
    end
  end

  // wishbone: one wait-free answer per request, ack the cycle after stb
  always_ff @(posedge clock) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wbReq;
      if (wbReq && !wb_we_i) begin
        unique case (wb_adr_i)
          pktbuf_pkg::ADDR_DATA_LO: wb_dat_o <= dataWord_q[31:0];
          pktbuf_pkg::ADDR_DATA_HI: wb_dat_o <= dataWord_q[63:32];
          pktbuf_pkg::ADDR_CMD: wb_dat_o <= {16'h0000, cmd_q & pktbuf_pkg::CMD_RW_MASK};
          pktbuf_pkg::ADDR_STAT: wb_dat_o <= {28'h000_0000, state_q};
          pktbuf_pkg::ADDR_ENG: wb_dat_o <= {16'h0000, collisions_q};
          default: wb_dat_o <= '0;
        endcase
      end
    end
  end
endmodule : packet_buffer_debug_access
`default_nettype wire

// ### rtl/pkt_sram.sv
// single-port 64-bit word memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module pkt_sram #(
  parameter int WORDS = 1024,
  parameter int AW = 10
) (
  // clock
  input wire logic clock,
  // access
  input wire logic en,
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [63:0] wdata,
  output logic [63:0] rdata
);
  logic [63:0] mem [WORDS];

  always_ff @(posedge clock) begin
    if (en) begin
      if (we) begin
        mem[addr] <= wdata;
      end
      rdata <= mem[addr];
    end
  end
endmodule : pkt_sram
`default_nettype wire

// ### test/packet_buffer_debug_access_chk.sv
// assertion checker for the packet buffer debug port
`timescale 1ns/1ps
`default_nettype none
module packet_buffer_debug_access_chk (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // engine port
  input wire logic engReq,
  input wire logic engGrant,
  input wire logic engValid,
  // header
  input wire logic [15:0] hdrNextPage,
  input wire logic [15:0] hdrSecondPage,
  input wire logic [15:0] hdrLength,
  input wire logic [63:0] hdrWord
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  a_ack_has_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_ack_idle_low: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack while idle");
  a_grant_has_req: assert property (engGrant |-> $past(engReq))
    else $error("grant without request");
  a_grant_spaced: assert property (engGrant |=> !engGrant)
    else $error("grants back to back");
  a_valid_after_grant: assert property (engValid |-> $past(engGrant))
    else $error("valid without grant");
  a_hdr_layout: assert property (!$past(reset) |-> hdrWord ==
    {$past(hdrNextPage), $past(hdrSecondPage), $past(hdrLength), ~$past(hdrLength)})
    else $error("header word wrong");
  c_bus_ack: cover property (wb_ack_o);
  c_eng_grant: cover property (engGrant);
  c_eng_valid: cover property (engValid);
endmodule : packet_buffer_debug_access_chk
bind packet_buffer_debug_access packet_buffer_debug_access_chk packet_buffer_debug_access_chk_inst (
  .clock, .reset, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .engReq, .engGrant, .engValid,
  .hdrNextPage, .hdrSecondPage, .hdrLength, .hdrWord);
`default_nettype wire

// ### test/tb_packet_buffer_debug_access.sv
// self-checking bench for the packet buffer debug port
`timescale 1ns/1ps
`default_nettype none
module tb_packet_buffer_debug_access;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, engGrant, engValid;
  logic engReq = 1'b0, engTx = 1'b0, engWe = 1'b0;
  logic [5:0] adr = 6'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] datI = 32'h0, datO;
  logic [9:0] engAddr = 10'h000;
  logic [63:0] engWdata = 64'h0, engRdata, hdrWord;
  logic [15:0] hdrN = 16'h0000, hdrS = 16'h0000, hdrL = 16'h0000;
  int failures = 0;
  int cmpCount = 0;
  localparam logic [63:0] VA = 64'h0807_0605_0403_0201;
  localparam logic [63:0] VB = 64'hF0E1_D2C3_B4A5_9687;
  localparam logic [63:0] VC = 64'h1357_9BDF_2468_ACE0;
  localparam logic [63:0] VD = 64'hA5A5_5A5A_0F0F_F0F0;

  packet_buffer_debug_access packet_buffer_debug_access_inst (
    .clock(clock), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(datI), .wb_dat_o(datO), .wb_ack_o(ack), .engReq(engReq), .engTx(engTx),
    .engWe(engWe), .engAddr(engAddr), .engWdata(engWdata), .engGrant(engGrant), .engValid(engValid),
    .engRdata(engRdata), .hdrNextPage(hdrN), .hdrSecondPage(hdrS), .hdrLength(hdrL), .hdrWord(hdrWord));

  initial begin
    forever #20 clock = ~clock;
  end

  task report_and_stop();
    if (failures == 0 && cmpCount > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop

  task cmp(input string what, input logic [63:0] exp, input logic [63:0] got);
    cmpCount++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  // one classic cycle; ack is looked at on the edge that samples it
  // no local limit: only the watchdog ends a wait for ack
  task wb(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    datI <= d;
    sel <= 4'hF;
    do begin
      @(posedge clock);
    end while (ack !== 1'b1);
    q = datO;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task poll();
    logic [31:0] q;
    int n;
    n = 0;
    do begin
      wb(1'b0, pktbuf_pkg::ADDR_CMD, 32'h0, q);
      n++;
    end while (q[pktbuf_pkg::CMD_GO_BIT] !== 1'b0 && n < 50);
    cmp("go cleared", 64'(q[14]), 64'h0);
  endtask : poll

  task dbg(input logic rd, input logic tx, input logic [9:0] a, input logic [63:0] wd, output logic [63:0] q);
    logic [31:0] lo, hi;
    if (!rd) begin
      wb(1'b1, pktbuf_pkg::ADDR_DATA_LO, wd[31:0], lo);
      wb(1'b1, pktbuf_pkg::ADDR_DATA_HI, wd[63:32], hi);
    end
    wb(1'b1, pktbuf_pkg::ADDR_CMD, {16'h0000, rd, 1'b1, tx, 3'b000, a}, lo);
    poll();
    wb(1'b0, pktbuf_pkg::ADDR_DATA_LO, 32'h0, lo);
    wb(1'b0, pktbuf_pkg::ADDR_DATA_HI, 32'h0, hi);
    q = {hi, lo};
  endtask : dbg

  task eng(input logic w, input logic tx, input logic [9:0] a, input logic [63:0] d, output logic [63:0] q);
    @(posedge clock);
    engReq <= 1'b1;
    engTx <= tx;
    engWe <= w;
    engAddr <= a;
    engWdata <= d;
    do begin
      @(posedge clock);
    end while (engGrant !== 1'b1);
    engReq <= 1'b0;
    while (!w && engValid !== 1'b1) begin
      @(posedge clock);
    end
    q = engRdata;
  endtask : eng

  task t_reset();
    logic [31:0] q;
    wb(1'b0, pktbuf_pkg::ADDR_CMD, 32'h0, q);
    cmp("cmd reset", 64'(q), 64'h0);
    wb(1'b0, pktbuf_pkg::ADDR_STAT, 32'h0, q);
    cmp("state idle", 64'(q), 64'h0000_0000_0000_0001);
    wb(1'b1, 6'h3C, 32'hFFFF_FFFF, q);
    wb(1'b0, 6'h3C, 32'h0, q);
    cmp("unmapped", 64'(q), 64'h0);
  endtask : t_reset

  // tx address drops bit 9, so 0x3ff and 0x1ff share a word there only
  task t_mem();
    logic [63:0] q;
    dbg(1'b0, 1'b0, 10'h3FF, VA, q);
    dbg(1'b0, 1'b1, 10'h1FF, VB, q);
    dbg(1'b0, 1'b0, 10'h1FF, VC, q);
    dbg(1'b1, 1'b0, 10'h3FF, 64'h0, q);
    cmp("rx 3ff", VA, q);
    dbg(1'b1, 1'b1, 10'h3FF, 64'h0, q);
    cmp("tx 3ff", VB, q);
    dbg(1'b1, 1'b0, 10'h1FF, 64'h0, q);
    cmp("rx 1ff", VC, q);
  endtask : t_mem

  task t_eng();
    logic [63:0] q;
    eng(1'b0, 1'b0, 10'h3FF, 64'h0, q);
    cmp("engine rx", VA, q);
    eng(1'b1, 1'b1, 10'h155, VD, q);
  endtask : t_eng

  // engine holds the memory, so the debug request must stay pending
  task t_pending();
    logic [31:0] q, lo;
    @(posedge clock);
    engReq <= 1'b1;
    engWe <= 1'b0;
    wb(1'b1, pktbuf_pkg::ADDR_CMD, 32'h0000_E155, q);
    wb(1'b0, pktbuf_pkg::ADDR_CMD, 32'h0, q);
    cmp("cmd pending", 64'(q), 64'h0000_E155);
    wb(1'b0, pktbuf_pkg::ADDR_STAT, 32'h0, q);
    cmp("state waiting", 64'(q), 64'h0000_0000_0000_0002);
    wb(1'b1, pktbuf_pkg::ADDR_CMD, 32'h0, q);
    wb(1'b0, pktbuf_pkg::ADDR_CMD, 32'h0, q);
    cmp("cmd zero write", 64'(q), 64'h0000_E155);
    engReq <= 1'b0;
    poll();
    wb(1'b0, pktbuf_pkg::ADDR_DATA_LO, 32'h0, lo);
    wb(1'b0, pktbuf_pkg::ADDR_DATA_HI, 32'h0, q);
    cmp("tx engine word", VD, {q, lo});
  endtask : t_pending

  task t_hdr();
    @(posedge clock);
    hdrN <= 16'h0003;
    hdrS <= 16'h0004;
    hdrL <= 16'h05EE;
    repeat (2) @(posedge clock);
    cmp("header", 64'h0003_0004_05EE_FA11, hdrWord);
  endtask : t_hdr

  initial begin
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    t_reset();
    t_mem();
    t_eng();
    t_pending();
    t_hdr();
    report_and_stop();
  end

  initial begin
    repeat (20000) @(posedge clock);
    failures++;
    report_and_stop();
  end
endmodule : tb_packet_buffer_debug_access
`default_nettype wire
